/* src/alpm_top.sv */
// Summary of operation
// - Normal mode keeps every block powered between conversions.
// - Light sleep is entered only while the light sleep enable bit is 1.
// - Light sleep powers down a subset of blocks during acquisition.
// - Enabled, a conversion ending with trigger high enters light sleep.
// - Light sleep lasts while the trigger stays high.
// - Trigger falling edge ends light sleep and starts waking blocks.
// - Cycle equals conversion time plus sleep time plus wake time.
// - Conversion time is fixed; spare cycle time goes to light sleep.
// - Deep sleep starts on chip select rising after the request.
// - Deep sleep drops all analog power; interface and registers stay.
// - Ready indicator stays high throughout deep sleep.
// - Leaving deep sleep keeps ready high; host waits the power-up time.
`default_nettype none
`include "alpm_cfg.svh"

module alpm_top (
   input  wire logic                    clock_i,
   input  wire logic                    reset_i,
   input  wire logic                    conversion_trigger_i,
   input  wire logic                    chip_select_n_i,
   input  wire logic                    cfg_write_i,
   input  wire logic [`ALPM_ADDR_W-1:0] cfg_addr_i,
   input  wire logic [`ALPM_DATA_W-1:0] cfg_data_i,
   output logic                         ready_indicator_o,
   output logic                         converting_o,
   output logic                         core_power_on_o,
   output logic                         light_blocks_on_o,
   output logic                         waking_o,
   output logic [`ALPM_DATA_W-1:0]      power_control_o
);

   localparam int CONV_D = `ALPM_CONV_CYC;
   localparam int LSW_D  = `ALPM_LS_WAKE_CYC;
   localparam int DSW_D  = `ALPM_DS_WAKE_CYC;

   // ----------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------
   // True when a configuration write hits the given address.
   function automatic logic hit(input logic                    wr,
                                input logic [`ALPM_ADDR_W-1:0] addr,
                                input logic [`ALPM_ADDR_W-1:0] target);
      hit = wr && (addr == target);
   endfunction : hit

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   alpm_pkg::alpm_state_type   state_reg;
   alpm_pkg::alpm_state_type   state_next;
   logic [`ALPM_DATA_W-1:0]    pctl_reg;
   logic [`ALPM_DATA_W-1:0]    pctl_next;
   logic                       unlock_reg;
   logic                       unlock_next;
   logic                       arm_reg;
   logic                       arm_next;
   logic                       trig_prev_reg;
   logic                       cs_n_prev_reg;
   logic                       ready_reg;
   logic                       ready_next;
   logic                       conv_reg;
   logic                       conv_next;
   logic                       core_reg;
   logic                       core_next;
   logic                       light_reg;
   logic                       light_next;
   logic                       wake_reg;
   logic                       wake_next;
   logic                       trig_rise;
   logic                       trig_fall;
   logic                       cs_rise;
   logic                       ls_en;
   logic                       ds_req;
   logic                       pctl_wr;
   logic                       key_wr;
   logic                       ds_go;

   alpm_tmr_if tmr_bus ();

   alpm_timer u_timer (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .tmr     (tmr_bus)
   );

   // ----------------------------------------------------------------------
   // Edge detection on the host pins
   // ----------------------------------------------------------------------
   // Edges are taken against the previous sample of each pin.
   assign trig_rise = conversion_trigger_i && !trig_prev_reg;
   assign trig_fall = !conversion_trigger_i && trig_prev_reg;
   assign cs_rise   = chip_select_n_i && !cs_n_prev_reg;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         trig_prev_reg <= 1'b0;
         cs_n_prev_reg <= 1'b1;
      end else begin
         trig_prev_reg <= conversion_trigger_i;
         cs_n_prev_reg <= chip_select_n_i;
      end
   end

   // ----------------------------------------------------------------------
   // Power control register and unlock
   // ----------------------------------------------------------------------
   assign ls_en   = pctl_reg[`ALPM_LS_EN_BIT];
   assign ds_req  = pctl_reg[`ALPM_DS_REQ_BIT];
   assign pctl_wr = hit(cfg_write_i, cfg_addr_i, `ALPM_PCTL_ADDR);
   assign key_wr  = hit(cfg_write_i, cfg_addr_i, `ALPM_UNLOCK_ADDR)
                    && (cfg_data_i == `ALPM_UNLOCK_KEY);

   // The key opens the request bit for one write; any other write relocks it.
   always_comb begin
      pctl_next   = pctl_reg;
      unlock_next = unlock_reg;
      if (key_wr) begin
         unlock_next = 1'b1;
      end else if (cfg_write_i) begin
         unlock_next = 1'b0;
      end
      if (pctl_wr) begin
         pctl_next = cfg_data_i;
         // A set without the unlock keeps the old request.
         if (cfg_data_i[`ALPM_DS_REQ_BIT] && !unlock_reg) begin
            pctl_next[`ALPM_DS_REQ_BIT] = ds_req;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pctl_reg   <= `ALPM_PCTL_RESET;
         unlock_reg <= 1'b0;
      end else begin
         pctl_reg   <= pctl_next;
         unlock_reg <= unlock_next;
      end
   end

   // ----------------------------------------------------------------------
   // Deep sleep arming
   // ----------------------------------------------------------------------
   // The chip select rising edge closing the request access arms entry.
   assign ds_go = arm_reg || (cs_rise && ds_req);

   // Entry waits out a running conversion; a cleared request disarms.
   always_comb begin
      arm_next = arm_reg;
      if (cs_rise && ds_req) begin
         arm_next = 1'b1;
      end
      if (state_next == alpm_pkg::DEEP_SLEEP
          || !pctl_next[`ALPM_DS_REQ_BIT]) begin
         arm_next = 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         arm_reg <= 1'b0;
      end else begin
         arm_reg <= arm_next;
      end
   end

   // ----------------------------------------------------------------------
   // Power state sequencer
   // ----------------------------------------------------------------------
   // Moves between acquisition, conversion, light and deep sleep.
   always_comb begin
      state_next    = state_reg;
      tmr_bus.start = 1'b0;
      tmr_bus.load  = '0;
      case (state_reg)
         alpm_pkg::ACQUIRE: begin
            if (ds_go) begin
               state_next = alpm_pkg::DEEP_SLEEP;
            end else if (trig_rise) begin
               state_next    = alpm_pkg::CONVERT;
               tmr_bus.start = 1'b1;
               tmr_bus.load  = `ALPM_CNT_W'(`ALPM_CONV_CYC);
            end
         end
         alpm_pkg::CONVERT: begin
            if (tmr_bus.expire) begin
               if (ds_go) begin
                  state_next = alpm_pkg::DEEP_SLEEP;
               end else if (ls_en && conversion_trigger_i) begin
                  state_next = alpm_pkg::LIGHT_SLEEP;
               end else begin
                  state_next = alpm_pkg::ACQUIRE;
               end
            end
         end
         alpm_pkg::LIGHT_SLEEP: begin
            if (ds_go) begin
               state_next = alpm_pkg::DEEP_SLEEP;
            end else if (!conversion_trigger_i) begin
               state_next    = alpm_pkg::LIGHT_WAKE;
               tmr_bus.start = 1'b1;
               tmr_bus.load  = `ALPM_CNT_W'(`ALPM_LS_WAKE_CYC);
            end
         end
         alpm_pkg::LIGHT_WAKE: begin
            if (tmr_bus.expire) begin
               state_next = alpm_pkg::ACQUIRE;
            end
         end
         alpm_pkg::DEEP_SLEEP: begin
            if (!ds_req) begin
               state_next    = alpm_pkg::DEEP_WAKE;
               tmr_bus.start = 1'b1;
               tmr_bus.load  = `ALPM_CNT_W'(`ALPM_DS_WAKE_CYC);
            end
         end
         alpm_pkg::DEEP_WAKE: begin
            if (tmr_bus.expire) begin
               state_next = alpm_pkg::ACQUIRE;
            end
         end
         default: begin
            state_next = alpm_pkg::ACQUIRE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_reg <= alpm_pkg::ACQUIRE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------------
   // Outputs follow the next state so they line up with the state register.
   always_comb begin
      conv_next  = (state_next == alpm_pkg::CONVERT);
      ready_next = (state_next != alpm_pkg::CONVERT);
      core_next  = (state_next != alpm_pkg::DEEP_SLEEP);
      light_next = (state_next != alpm_pkg::DEEP_SLEEP)
                   && (state_next != alpm_pkg::LIGHT_SLEEP);
      wake_next  = (state_next == alpm_pkg::LIGHT_WAKE)
                   || (state_next == alpm_pkg::DEEP_WAKE);
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         conv_reg  <= 1'b0;
         ready_reg <= 1'b1;
         core_reg  <= 1'b1;
         light_reg <= 1'b1;
         wake_reg  <= 1'b0;
      end else begin
         conv_reg  <= conv_next;
         ready_reg <= ready_next;
         core_reg  <= core_next;
         light_reg <= light_next;
         wake_reg  <= wake_next;
      end
   end

   assign converting_o      = conv_reg;
   assign ready_indicator_o = ready_reg;
   assign core_power_on_o   = core_reg;
   assign light_blocks_on_o = light_reg;
   assign waking_o          = wake_reg;
   assign power_control_o   = pctl_reg;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   // Without light sleep enabled, acquisition keeps every block powered.
   a_normal_power: assert property (
      (!ls_en && !ds_req && state_reg == alpm_pkg::ACQUIRE)
      |-> (core_power_on_o && light_blocks_on_o))
      else $error("Blocks powered down in normal mode.");

   // Light sleep is only entered with the enable bit set.
   a_ls_gate: assert property (
      $rose(state_reg == alpm_pkg::LIGHT_SLEEP) |-> $past(ls_en))
      else $error("Light sleep entered while disabled.");

   // Light sleep drops the subset and keeps the core powered.
   a_ls_power: assert property (
      (state_reg == alpm_pkg::LIGHT_SLEEP)
      |-> (!light_blocks_on_o && core_power_on_o))
      else $error("Wrong power pattern in light sleep.");

   // End of conversion with trigger high enters light sleep.
   a_ls_entry: assert property (
      (state_reg == alpm_pkg::CONVERT && tmr_bus.expire && ls_en
       && conversion_trigger_i && !ds_go)
      |=> (state_reg == alpm_pkg::LIGHT_SLEEP))
      else $error("Light sleep not entered after conversion.");

   // Light sleep holds while the trigger stays high.
   a_ls_hold: assert property (
      (state_reg == alpm_pkg::LIGHT_SLEEP && conversion_trigger_i && !ds_go)
      |=> (state_reg == alpm_pkg::LIGHT_SLEEP))
      else $error("Light sleep left with trigger high.");

   // A falling trigger wakes the blocks and returns to acquisition in time.
   a_ls_exit: assert property (
      (state_reg == alpm_pkg::LIGHT_SLEEP && trig_fall && !ds_go)
      |=> waking_o ##LSW_D
          (state_reg == alpm_pkg::ACQUIRE && light_blocks_on_o))
      else $error("Light sleep wake sequence wrong.");

   // Conversion lasts exactly the fixed conversion time.
   a_conv_fixed: assert property (
      $rose(state_reg == alpm_pkg::CONVERT)
      |-> ##(CONV_D - 1) converting_o ##1 !converting_o)
      else $error("Conversion length wrong.");

   // Chip select rising with the request set enters deep sleep.
   a_ds_entry: assert property (
      (cs_rise && ds_req && state_reg == alpm_pkg::ACQUIRE)
      |=> (state_reg == alpm_pkg::DEEP_SLEEP))
      else $error("Deep sleep not entered on chip select.");

   // Deep sleep powers everything down, ready high, register kept.
   a_ds_state: assert property (
      (state_reg == alpm_pkg::DEEP_SLEEP)
      |-> (!core_power_on_o && !light_blocks_on_o
           && ready_indicator_o))
      else $error("Wrong outputs in deep sleep.");

   // Without a write, deep sleep leaves the register contents alone.
   a_ds_keep: assert property (
      (state_reg == alpm_pkg::DEEP_SLEEP && !cfg_write_i)
      |=> $stable(power_control_o))
      else $error("Register changed in deep sleep.");

   // Clearing the request starts power-up with ready high.
   a_ds_exit: assert property (
      (state_reg == alpm_pkg::DEEP_SLEEP && !ds_req)
      |=> (ready_indicator_o && waking_o
           && state_reg == alpm_pkg::DEEP_WAKE))
      else $error("Deep sleep exit sequence wrong.");

   // Counts power-up cycles; the wait is too long for a plain delay.
   logic [`ALPM_CNT_W-1:0] dsw_cnt_reg;
   logic [`ALPM_CNT_W-1:0] dsw_cnt_next;

   always_comb begin
      dsw_cnt_next = '0;
      if (state_reg == alpm_pkg::DEEP_WAKE) begin
         dsw_cnt_next = dsw_cnt_reg + `ALPM_CNT_W'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         dsw_cnt_reg <= '0;
      end else begin
         dsw_cnt_reg <= dsw_cnt_next;
      end
   end

   // Power-up lasts exactly its fixed length, then acquisition follows.
   a_ds_wake_len: assert property (
      $fell(state_reg == alpm_pkg::DEEP_WAKE)
      |-> (state_reg == alpm_pkg::ACQUIRE
           && dsw_cnt_reg == `ALPM_CNT_W'(DSW_D)))
      else $error("Deep sleep power-up length wrong.");

   // A request set without the unlock is not taken.
   a_ds_lock: assert property (
      (pctl_wr && cfg_data_i[`ALPM_DS_REQ_BIT] && !unlock_reg && !ds_req)
      |=> !ds_req)
      else $error("Locked deep sleep request accepted.");

   c_light_cycle: cover property (
      (state_reg == alpm_pkg::LIGHT_SLEEP) ##[1:50]
      (state_reg == alpm_pkg::LIGHT_WAKE));
   c_deep_cycle: cover property (
      (state_reg == alpm_pkg::DEEP_SLEEP) ##[1:50]
      (state_reg == alpm_pkg::DEEP_WAKE));
   c_locked_set: cover property (
      pctl_wr && cfg_data_i[`ALPM_DS_REQ_BIT] && !unlock_reg);

endmodule : alpm_top

`default_nettype wire

/* shared/alpm_cfg.svh */
`ifndef ALPM_CFG_SVH
`define ALPM_CFG_SVH

// ----------------------------------------------------------------------
// Clock rate and timing figures
// ----------------------------------------------------------------------
// Clock rate in MHz.
`define ALPM_CLK_MHZ      25
// Conversion time in ns.
`define ALPM_CONV_NS      400
// Light sleep wake-up time in ns.
`define ALPM_LS_WAKE_NS   200
// Deep sleep power-up time in ns.
`define ALPM_DS_WAKE_NS   40000
// Least times round up to whole cycles.
`define ALPM_NS2CYC(ns)   (((ns) * `ALPM_CLK_MHZ + 999) / 1000)
`define ALPM_CONV_CYC     `ALPM_NS2CYC(`ALPM_CONV_NS)
`define ALPM_LS_WAKE_CYC  `ALPM_NS2CYC(`ALPM_LS_WAKE_NS)
`define ALPM_DS_WAKE_CYC  `ALPM_NS2CYC(`ALPM_DS_WAKE_NS)

// ----------------------------------------------------------------------
// Configuration write port
// ----------------------------------------------------------------------
`define ALPM_ADDR_W       8
`define ALPM_DATA_W       8
`define ALPM_CNT_W        16
// Address of the unlock key register and the key itself.
`define ALPM_UNLOCK_ADDR  8'h11
`define ALPM_UNLOCK_KEY   8'h69
// Address of the power control register.
`define ALPM_PCTL_ADDR    8'h10
// Field positions within the power control register.
`define ALPM_LS_EN_BIT    0
`define ALPM_DS_REQ_BIT   1
`define ALPM_PCTL_RESET   8'h00

`endif

/* shared/alpm_pkg.sv */
`default_nettype none

package alpm_pkg;

   // ----------------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------------
   // Operating states of the sequencer.
   typedef enum logic [2:0] {
      ACQUIRE,
      CONVERT,
      LIGHT_SLEEP,
      LIGHT_WAKE,
      DEEP_SLEEP,
      DEEP_WAKE
   } alpm_state_type;

endpackage : alpm_pkg

`default_nettype wire

/* shared/alpm_tmr_if.sv */
`default_nettype none
`include "alpm_cfg.svh"

// ----------------------------------------------------------------------
// Interval timer carrier
// ----------------------------------------------------------------------
interface alpm_tmr_if;
   logic                   start;
   logic [`ALPM_CNT_W-1:0] load;
   logic                   expire;

   modport ctrl (output start, output load, input expire);
   modport tmr  (input start, input load, output expire);
endinterface : alpm_tmr_if

`default_nettype wire

/* src/alpm_timer.sv */
`default_nettype none
`include "alpm_cfg.svh"

module alpm_timer (
   input  wire logic clock_i,
   input  wire logic reset_i,
   alpm_tmr_if.tmr   tmr
);

   logic [`ALPM_CNT_W-1:0] count_reg;
   logic [`ALPM_CNT_W-1:0] count_next;

   // A start loads the interval; otherwise the count runs down to zero.
   always_comb begin
      count_next = count_reg;
      if (tmr.start) begin
         count_next = tmr.load;
      end else if (count_reg != '0) begin
         count_next = count_reg - `ALPM_CNT_W'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   // Expiry marks the last cycle of the interval.
   assign tmr.expire = (count_reg == `ALPM_CNT_W'(1));

endmodule : alpm_timer

`default_nettype wire

/* tb/alpm_host_model.sv */
`default_nettype none
`include "alpm_cfg.svh"

// ----------------------------------------------------------------------
// Host controller model
// ----------------------------------------------------------------------
module alpm_host_model (
   input  wire logic                    clock_i,
   output logic                         trigger_o,
   output logic                         chip_select_n_o,
   output logic                         write_o,
   output logic [`ALPM_ADDR_W-1:0]      addr_o,
   output logic [`ALPM_DATA_W-1:0]      data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels from time zero: deselected, no write, trigger low.
   initial begin
      trigger_o       = 1'b0;
      chip_select_n_o = 1'b1;
      write_o         = 1'b0;
      addr_o          = 8'h00;
      data_o          = 8'h00;
   end

   // One framed write; the closing chip select rise ends the access.
   task automatic write_reg(input logic [`ALPM_ADDR_W-1:0] a,
                            input logic [`ALPM_DATA_W-1:0] d);
      @(negedge clock_i) chip_select_n_o = 1'b0;
      @(negedge clock_i) begin
         write_o = 1'b1;
         addr_o  = a;
         data_o  = d;
      end
      @(negedge clock_i) begin
         write_o = 1'b0;
         addr_o  = ~a; // Released bus never shows the stale value.
         data_o  = ~d;
      end
      @(negedge clock_i) chip_select_n_o = 1'b1;
   endtask : write_reg

   // Key write that must come just before a deep sleep request.
   task automatic unlock();
      write_reg(`ALPM_UNLOCK_ADDR, `ALPM_UNLOCK_KEY);
   endtask : unlock

   // Drives the trigger pin to a new level.
   task automatic set_trigger(input logic v);
      @(negedge clock_i) trigger_o = v;
   endtask : set_trigger

   // Drops the trigger and keeps it low for the whole wake time.
   task automatic drop_trigger();
      set_trigger(1'b0);
      repeat (`ALPM_LS_WAKE_CYC + 1) @(negedge clock_i);
   endtask : drop_trigger

endmodule : alpm_host_model

`default_nettype wire

/* tb/alpm_top_test.sv */
`default_nettype none
`include "alpm_cfg.svh"

module alpm_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                    clock;
   logic                    reset;
   logic                    trigger;
   logic                    chip_select_n;
   logic                    cfg_write;
   logic [`ALPM_ADDR_W-1:0] cfg_addr;
   logic [`ALPM_DATA_W-1:0] cfg_data;
   logic                    ready;
   logic                    converting;
   logic                    core_on;
   logic                    light_on;
   logic                    waking;
   logic [`ALPM_DATA_W-1:0] power_control;
   int                      err_count;
   int                      check_count;
   int                      n;

   // ----------------------------------------------------------------------
   // Clock, reset and instances
   // ----------------------------------------------------------------------
   // Clock at 25 MHz.
   initial clock = 1'b0;
   always #20 clock = ~clock;

   alpm_top u_alpm_top (
      .clock_i              (clock),
      .reset_i              (reset),
      .conversion_trigger_i (trigger),
      .chip_select_n_i      (chip_select_n),
      .cfg_write_i          (cfg_write),
      .cfg_addr_i           (cfg_addr),
      .cfg_data_i           (cfg_data),
      .ready_indicator_o    (ready),
      .converting_o         (converting),
      .core_power_on_o      (core_on),
      .light_blocks_on_o    (light_on),
      .waking_o             (waking),
      .power_control_o      (power_control)
   );

   alpm_host_model u_alpm_host_model (
      .clock_i         (clock),
      .trigger_o       (trigger),
      .chip_select_n_o (chip_select_n),
      .write_o         (cfg_write),
      .addr_o          (cfg_addr),
      .data_o          (cfg_data)
   );

   // ----------------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------------
   // Compares one value and counts the outcome.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD at %0t: %s saw %h want %h", $time, what, seen, exp);
      end
   endtask : check

   // Selects a status output: 0 converting, 1 waking.
   function automatic logic pick(input int k);
      return (k == 0) ? converting : waking;
   endfunction : pick

   // Waits boundedly for a status to rise, then counts its high cycles.
   task automatic count_high(input int k, output int cnt);
      int w;
      w = 0;
      cnt = 0;
      while (pick(k) !== 1'b1 && w < 20) begin
         w++;
         @(negedge clock);
      end
      while (pick(k) === 1'b1 && cnt < 2000) begin
         cnt++;
         @(negedge clock);
      end
   endtask : count_high

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Conversion with light sleep off: everything stays powered.
   task automatic t_normal();
      u_alpm_host_model.set_trigger(1'b1);
      count_high(0, n);
      check(n, `ALPM_CONV_CYC, "conversion length");
      repeat (20) begin
         check(light_on, 1'b1, "blocks stay on");
         @(negedge clock);
      end
      u_alpm_host_model.drop_trigger();
      check(waking, 1'b0, "no wake without sleep");
   endtask : t_normal

   // Light sleep held for a while, woken by the trigger fall.
   task automatic t_light();
      u_alpm_host_model.write_reg(`ALPM_PCTL_ADDR, 8'h01);
      check(power_control, 8'h01, "enable bit");
      u_alpm_host_model.set_trigger(1'b1);
      count_high(0, n);
      check(n, `ALPM_CONV_CYC, "conversion length");
      check(light_on, 1'b0, "light sleep entry");
      repeat (30) begin
         check({light_on, core_on}, 2'b01, "light sleep kept");
         @(negedge clock);
      end
      u_alpm_host_model.set_trigger(1'b0);
      count_high(1, n);
      check(n, `ALPM_LS_WAKE_CYC, "light wake length");
      check(light_on, 1'b1, "blocks back on");
      u_alpm_host_model.set_trigger(1'b1);
      count_high(0, n);
      check(n, `ALPM_CONV_CYC, "next conversion");
      u_alpm_host_model.drop_trigger();
   endtask : t_light

   // Deep sleep requests that lack a fresh unlock are refused.
   task automatic t_locked();
      u_alpm_host_model.write_reg(`ALPM_PCTL_ADDR, 8'h03);
      check(power_control, 8'h01, "locked request");
      u_alpm_host_model.unlock();
      u_alpm_host_model.write_reg(8'h12, 8'h00);
      u_alpm_host_model.write_reg(`ALPM_PCTL_ADDR, 8'h02);
      check(power_control, 8'h00, "spent unlock");
      check(core_on, 1'b1, "still powered");
   endtask : t_locked

   // Deep sleep entry, ignored trigger, exit and power-up.
   task automatic t_deep();
      u_alpm_host_model.unlock();
      u_alpm_host_model.write_reg(`ALPM_PCTL_ADDR, 8'h02);
      repeat (2) @(negedge clock);
      check(power_control, 8'h02, "request stored");
      check({core_on, light_on}, 2'b00, "analog off");
      u_alpm_host_model.set_trigger(1'b1);
      repeat (20) begin
         check({ready, converting}, 2'b10, "ready in deep");
         @(negedge clock);
      end
      u_alpm_host_model.set_trigger(1'b0);
      u_alpm_host_model.write_reg(`ALPM_PCTL_ADDR, 8'h00);
      check({ready, core_on}, 2'b11, "exit ready");
      count_high(1, n);
      check(n, `ALPM_DS_WAKE_CYC, "power-up length");
      u_alpm_host_model.set_trigger(1'b1);
      count_high(0, n);
      check(n, `ALPM_CONV_CYC, "conversion after exit");
      u_alpm_host_model.drop_trigger();
   endtask : t_deep

   // ----------------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------------
   // Resets for 16 cycles, checks reset levels, runs every scenario.
   initial begin
      err_count   = 0;
      check_count = 0;
      reset       = 1'b1;
      repeat (16) @(posedge clock);
      @(negedge clock) reset = 1'b0;
      check({ready, converting, core_on, light_on, waking}, 5'h16,
            "reset levels");
      check(power_control, `ALPM_PCTL_RESET, "reset register");
      t_normal();
      t_light();
      t_locked();
      t_deep();
      final_report();
   end

   // Cuts a hang short well past the expected run of about 1200 cycles.
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      $display("BAD at %0t: watchdog expired", $time);
      final_report();
   end

endmodule : alpm_top_test

`default_nettype wire
